// *** hdl/sa_hdlc_link.sv ***
// Sa-bit HDLC link controller with AXI4-Lite registers and byte FIFOs
// How it works
// - Link bits travel only in National_bit_select_field of TS0 in non-alignment frames.
// - Each set select bit adds its Sa position, 4 kbit/s each.
// - Enabled receiver finds flags, removes stuffed zeros, stores bytes in FIFO.
// - Receiver disabled: controller idle, FIFO emptied, receive requests suppressed.
// - Transmitter enabled with empty FIFO sends continuous flags.
// - Transmitter takes bytes from its FIFO and frames them into a message.
// - Transmitter disabled: controller idle, FIFO emptied, transmit requests suppressed.
// - Abort set: finish current data byte, then send zero and seven ones.
// - After the abort pattern, transmit FIFO is emptied and flags follow.
// - Software marks last byte; when FIFO drains, a 16-bit check follows.
// - After the closing check sequence, transmit raises an interrupt request.
// - Receive half enable: request at half full and at message end.
// - Transmit half enable: request at half full and at message end.
// - Half enable clear: requests only at message end or overflow.
// - Transmit and receive FIFOs each hold 16 bytes.
// - Transmit bytes leave bit 0 first, bit 7 last.
`timescale 1ns/10ps
module sa_hdlc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic flush, // Empty the buffer
  input wire logic [WIDTH-1:0] in_data, // Fill word
  input wire logic in_valid, // Fill request
  output logic in_ready, // Room left
  output logic [WIDTH-1:0] out_data, // Head word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Drain request
  output logic [$clog2(DEPTH):0] level // Words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data = mem[rp_ff];
  assign level = cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= wp_ff + AW'(push);
      rp_ff <= rp_ff + AW'(pop);
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule // sa_hdlc_fifo

module sa_hdlc_link (
  input wire logic aclk, // Clock, 100 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic [sa_hdlc_pkg::ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address taken
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte enables
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data taken
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response taken
  input wire logic [sa_hdlc_pkg::ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address taken
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data taken
  input wire logic sa_strobe, // One Sa bit time of TS0, NFAS frame
  input wire logic [2:0] sa_pos, // 0..4 = National_bit_select_field
  input wire logic rx_sa_bit, // Received Sa bit
  output logic tx_sa_bit, // Transmitted Sa bit
  output logic tx_irq, // Transmit request pulse
  output logic rx_irq // Receive request pulse
);
  import sa_hdlc_pkg::*;

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [4:0] sasel_ff;
  logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  tx_state_t tst_ff, nxt_tst;
  logic [7:0] tsh_ff, nxt_tsh;
  logic [2:0] tcnt_ff, nxt_tcnt, tones_ff, nxt_tones;
  logic tstuff_ff, nxt_tstuff, tx_sa_bit_ff, nxt_tbit, tx_irq_ff, rx_irq_ff;
  logic [15:0] tcrc_ff, nxt_tcrc;
  logic tx_pop, eom_done, abort_done;
  logic [7:0] rsh_ff, rh0_ff, rh1_ff;
  logic [2:0] rcnt_ff, rones_ff;
  logic [1:0] rhc_ff;
  logic rin_ff;
  logic [15:0] rcrc_ff;
  logic [7:0] tx_fd, rx_fd;
  logic tx_fv, tx_in_ready, rx_fv, rx_in_ready;
  logic [4:0] tx_lvl, rx_lvl;

  // Sa slot decode
  wire tx_en = ctrl_ff[TXEN_BIT];
  wire rx_en = ctrl_ff[RXEN_BIT];
  wire sa_sel = sa_strobe && (sa_pos < SA_POS_CNT) && sasel_ff[sa_pos];
  wire tx_slot = tx_en && sa_sel;
  wire rx_slot = rx_en && sa_sel;

  // Bus decode
  wire wr_txd = awaddr == TXD_ADDR;
  wire wr_map = (awaddr == CTRL_ADDR) || (awaddr == SASEL_ADDR) || wr_txd;
  wire wr_go = awvalid && wvalid && !awready_ff && !bvalid_ff && (!wr_txd || tx_in_ready);
  wire wr_fire = awready_ff && awvalid;
  wire wr_lo = wr_fire && wstrb[0];
  wire wr_ctrl = wr_lo && (awaddr == CTRL_ADDR);
  wire wr_sasel = wr_lo && (awaddr == SASEL_ADDR);
  wire tx_push = wr_lo && wr_txd;
  wire rd_go = arvalid && !arready_ff && !rvalid_ff;
  wire rd_fire = arready_ff && arvalid;
  wire rd_rxd = araddr == RXD_ADDR;
  wire rx_pop = rd_fire && rd_rxd && rx_fv;
  wire rd_map = (araddr == CTRL_ADDR) || (araddr == SASEL_ADDR) || (araddr == TXD_ADDR)
                || rd_rxd || (araddr == STAT_ADDR);
  wire tx_busy = tst_ff != TX_FLAG;
  wire [31:0] stat_word = {14'h0000, tx_busy, rin_ff, 3'h0, tx_lvl, 3'h0, rx_lvl};
  wire [31:0] rd_word = (araddr == CTRL_ADDR) ? {24'h00_0000, ctrl_ff} :
                        (araddr == SASEL_ADDR) ? {27'h000_0000, sasel_ff} :
                        (rd_rxd && rx_fv) ? {24'h00_0000, rx_fd} :
                        (araddr == STAT_ADDR) ? stat_word : 32'h0000_0000;

  // Transmit bit engine
  wire stuff_now = tstuff_ff && (tones_ff == 3'h5);
  wire tx_load = tx_slot && !stuff_now && (tcnt_ff == LAST_BIT);
  wire tx_head = tsh_ff[0];
  wire [15:0] tcrc_bit = (tst_ff == TX_DATA) ? crc_bit(tcrc_ff, tx_head) : tcrc_ff;
  wire tx_flush = !tx_en || abort_done;

  always_comb begin
    nxt_tst = tst_ff;
    nxt_tsh = tsh_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tones = tones_ff;
    nxt_tstuff = tstuff_ff;
    nxt_tcrc = tcrc_ff;
    nxt_tbit = tx_sa_bit_ff;
    tx_pop = 1'b0;
    eom_done = 1'b0;
    abort_done = 1'b0;
    if (!tx_en) begin
      nxt_tst = TX_FLAG;
      nxt_tsh = FLAG_PAT;
      nxt_tcnt = '0;
      nxt_tones = '0;
      nxt_tstuff = 1'b0;
      nxt_tbit = 1'b1;
    end else if (tx_slot && stuff_now) begin
      nxt_tbit = 1'b0;
      nxt_tones = '0;
      // A stuff owed by the last check bit ends stuffing before the flag
      nxt_tstuff = tstuff_ff && (tst_ff != TX_FLAG);
    end else if (tx_slot) begin
      nxt_tbit = tx_head;
      nxt_tsh = {1'b0, tsh_ff[7:1]};
      nxt_tones = (tstuff_ff && tx_head) ? tones_ff + 3'h1 : 3'h0;
      nxt_tcrc = tcrc_bit;
      nxt_tcnt = tcnt_ff + 3'h1;
      if (tcnt_ff == LAST_BIT) begin
        nxt_tstuff = 1'b1;
        case (tst_ff)
          TX_FLAG: begin
            if (tx_fv) begin
              tx_pop = 1'b1;
              nxt_tsh = tx_fd;
              nxt_tcrc = CRC_INIT;
              nxt_tst = TX_DATA;
            end else begin
              nxt_tsh = FLAG_PAT;
              nxt_tstuff = 1'b0;
            end
          end
          TX_DATA: begin
            if (ctrl_ff[ABORT_BIT] || (!tx_fv && !ctrl_ff[EOM_BIT])) begin
              nxt_tsh = ABORT_PAT;
              nxt_tstuff = 1'b0;
              nxt_tst = TX_ABORT;
            end else if (tx_fv) begin
              tx_pop = 1'b1;
              nxt_tsh = tx_fd;
            end else begin
              nxt_tsh = ~tcrc_bit[7:0];
              nxt_tst = TX_CRC_LO;
            end
          end
          TX_CRC_LO: begin
            nxt_tsh = ~tcrc_ff[15:8];
            nxt_tst = TX_CRC_HI;
          end
          TX_CRC_HI: begin
            nxt_tsh = FLAG_PAT;
            // Five trailing ones still need their zero ahead of the flag
            nxt_tstuff = nxt_tones == 3'h5;
            nxt_tst = TX_FLAG;
            eom_done = 1'b1;
          end
          TX_ABORT: begin
            nxt_tsh = FLAG_PAT;
            nxt_tstuff = 1'b0;
            nxt_tst = TX_FLAG;
            abort_done = 1'b1;
          end
          default: begin
            nxt_tsh = FLAG_PAT;
            nxt_tstuff = 1'b0;
            nxt_tst = TX_FLAG;
          end
        endcase
      end
    end
  end

  // Software writes win over the hardware clears
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (abort_done) begin
      nxt_ctrl[ABORT_BIT] = 1'b0;
    end
    if (eom_done) begin
      nxt_ctrl[EOM_BIT] = 1'b0;
    end
    if (wr_ctrl) begin
      nxt_ctrl = wdata[7:0] & CTRL_MASK;
    end
  end

  wire tx_half = ctrl_ff[TX_HALF_LEVEL_IRQ_ENABLE_BIT] && tx_pop && (tx_lvl == HALF_LVL + 5'h01);
  wire tx_req = tx_en && (eom_done || tx_half);

  // Receive bit engine
  wire r_stuff = (rones_ff == 3'h5) && !rx_sa_bit;
  wire r_flag = (rones_ff == 3'h6) && !rx_sa_bit;
  wire r_abort = (rones_ff == 3'h6) && rx_sa_bit;
  wire r_data = rx_slot && rin_ff && !r_stuff && !r_flag && !r_abort;
  wire [7:0] r_byte = {rx_sa_bit, rsh_ff[7:1]};
  wire r_done = r_data && (rcnt_ff == LAST_BIT);
  wire [2:0] rones_inc = (rones_ff == 3'h7) ? rones_ff : rones_ff + 3'h1;
  wire r_end = rx_slot && r_flag && rin_ff && (rhc_ff == 2'h2) && (rcnt_ff == LAST_BIT)
               && (rcrc_ff == CRC_GOOD);
  wire rx_push = r_done && (rhc_ff == 2'h2);
  wire r_ovf = rx_push && !rx_in_ready;
  wire rx_half = ctrl_ff[RX_HALF_LEVEL_IRQ_ENABLE_BIT] && rx_push && rx_in_ready
                 && (rx_lvl == HALF_LVL - 5'h01);
  wire rx_req = rx_en && (r_end || r_ovf || rx_half);

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      rin_ff <= 1'b0;
      rones_ff <= '0;
      rcnt_ff <= '0;
      rhc_ff <= '0;
      rsh_ff <= '0;
      rcrc_ff <= CRC_INIT;
    end else if (rx_slot) begin
      rones_ff <= rx_sa_bit ? rones_inc : 3'h0;
      if (r_flag) begin
        rin_ff <= 1'b1;
        rcnt_ff <= '0;
        rhc_ff <= '0;
        rcrc_ff <= CRC_INIT;
      end else if (r_abort) begin
        rin_ff <= 1'b0;
        rhc_ff <= '0;
      end else if (r_data) begin
        rsh_ff <= r_byte;
        rcnt_ff <= rcnt_ff + 3'h1;
        if (r_done) begin
          rcrc_ff <= crc_byte(rcrc_ff, r_byte);
          rhc_ff <= (rhc_ff == 2'h2) ? rhc_ff : rhc_ff + 2'h1;
        end
      end
    end
  end

  // Two-byte hold keeps the check bytes out of the FIFO
  always_ff @(posedge aclk) begin
    if (r_done) begin
      rh0_ff <= r_byte;
      rh1_ff <= rh0_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      sasel_ff <= SASEL_RST;
      tst_ff <= TX_FLAG;
      tsh_ff <= FLAG_PAT;
      tcnt_ff <= '0;
      tones_ff <= '0;
      tstuff_ff <= 1'b0;
      tcrc_ff <= CRC_INIT;
      tx_sa_bit_ff <= 1'b1;
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      sasel_ff <= wr_sasel ? wdata[4:0] : sasel_ff;
      tst_ff <= nxt_tst;
      tsh_ff <= nxt_tsh;
      tcnt_ff <= nxt_tcnt;
      tones_ff <= nxt_tones;
      tstuff_ff <= nxt_tstuff;
      tcrc_ff <= nxt_tcrc;
      tx_sa_bit_ff <= nxt_tbit;
      tx_irq_ff <= tx_req;
      rx_irq_ff <= rx_req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else begin
      awready_ff <= wr_go;
      bvalid_ff <= wr_fire || (bvalid_ff && !bready);
      bresp_ff <= wr_fire ? (wr_map ? RESP_OKAY : RESP_SLVERR) : bresp_ff;
      arready_ff <= rd_go;
      rvalid_ff <= rd_fire || (rvalid_ff && !rready);
      rresp_ff <= rd_fire ? (rd_map ? RESP_OKAY : RESP_SLVERR) : rresp_ff;
      rdata_ff <= rd_fire ? rd_word : rdata_ff;
    end
  end

  sa_hdlc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(tx_flush),
    .in_data(wdata[7:0]),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .out_data(tx_fd),
    .out_valid(tx_fv),
    .out_ready(tx_pop),
    .level(tx_lvl)
  );

  sa_hdlc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(!rx_en),
    .in_data(rh1_ff),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .out_data(rx_fd),
    .out_valid(rx_fv),
    .out_ready(rx_pop),
    .level(rx_lvl)
  );

  assign awready = awready_ff;
  assign wready = awready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign tx_sa_bit = tx_sa_bit_ff;
  assign tx_irq = tx_irq_ff;
  assign rx_irq = rx_irq_ff;

  AST_SA_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_en && !tx_slot |=> $stable(tx_sa_bit_ff)) else $error("Sa bit moved outside a slot");
  AST_RX_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_en |=> rx_lvl == 5'h00 && !rx_irq_ff) else $error("Receive not idle when off");
  AST_TX_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_load && tst_ff == TX_FLAG && !tx_fv |=> tsh_ff == FLAG_PAT) else $error("No idle flag");
  AST_TX_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !tx_en |=> tx_lvl == 5'h00 && !tx_irq_ff && tx_sa_bit_ff) else $error("Transmit not idle");
  AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_load && tst_ff == TX_DATA && ctrl_ff[ABORT_BIT] |=> tsh_ff == ABORT_PAT)
    else $error("Abort pattern not loaded");
  AST_ABORT_FLUSH: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_load && tst_ff == TX_ABORT |=> tx_lvl == 5'h00 && tst_ff == TX_FLAG)
    else $error("FIFO not emptied after abort");
  AST_EOM_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_load && tst_ff == TX_CRC_HI |=> tx_irq_ff && tst_ff == TX_FLAG)
    else $error("No request after check sequence");
  AST_LSB: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_slot && !stuff_now |=> tx_sa_bit_ff == $past(tx_head)) else $error("Bit order wrong");
  AST_STUFF: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_slot && stuff_now |=> !tx_sa_bit_ff) else $error("Stuffed zero missing");
  AST_RX_HALF: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff[RX_HALF_LEVEL_IRQ_ENABLE_BIT] && !r_end && !r_ovf |=> !rx_irq_ff) else $error("Spurious rx request");
endmodule // sa_hdlc_link

// *** shared/sa_hdlc_pkg.sv ***
// Constants, state type and CRC helpers for the Sa-bit HDLC link controller
package sa_hdlc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_ADDR = 12'h0108;
  localparam logic [11:0] SASEL_ADDR = 12'h010C;
  localparam logic [11:0] TXD_ADDR = 12'h0110;
  localparam logic [11:0] RXD_ADDR = 12'h0114;
  localparam logic [11:0] STAT_ADDR = 12'h0118;
  localparam int RXEN_BIT = 7;
  localparam int TXEN_BIT = 6;
  localparam int ABORT_BIT = 5;
  localparam int EOM_BIT = 4;
  localparam int RX_HALF_LEVEL_IRQ_ENABLE_BIT = 3;
  localparam int TX_HALF_LEVEL_IRQ_ENABLE_BIT = 2;
  localparam logic [7:0] CTRL_MASK = 8'hFC;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] SASEL_RST = 5'h00;
  localparam logic [2:0] SA_POS_CNT = 3'h5;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] HALF_LVL = 5'h08;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] FLAG_PAT = 8'h7E;
  localparam logic [7:0] ABORT_PAT = 8'hFE;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    TX_FLAG = 5'b00001,
    TX_DATA = 5'b00010,
    TX_CRC_LO = 5'b00100,
    TX_CRC_HI = 5'b01000,
    TX_ABORT = 5'b10000
  } tx_state_t;

  // Reflected CCITT step, one bit
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = crc_bit(r, d[i]);
    end
    crc_byte = r;
  endfunction
endpackage

// *** tb/sa_far_end.sv ***
// Far-end model: Sa strobe timing, loopback of the link and line pattern counters
`timescale 1ns/10ps
module sa_far_end (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic run, // Frames flowing
  input wire logic [4:0] sel, // Positions the far end uses
  input wire logic tx_sa_bit, // Bit from the device
  output logic sa_strobe, // Sa bit time
  output logic [2:0] sa_pos, // Slot, 5..7 are unused slots
  output logic rx_sa_bit, // Bit to the device
  output logic [15:0] flag_cnt, // Flags seen
  output logic [15:0] abort_cnt // Runs of seven ones seen
);
  logic [7:0] last8;
  logic [2:0] ones;
  logic [7:0] nxt_last8;
  wire take = sa_strobe && (sa_pos < 3'h5) && sel[sa_pos];
  assign nxt_last8 = {tx_sa_bit, last8[7:1]};
  always @(posedge aclk) begin
    if (!aresetn) begin
      sa_strobe <= 1'b0;
      sa_pos <= 3'h0;
      rx_sa_bit <= 1'b1;
      last8 <= 8'h00;
      ones <= 3'h0;
      flag_cnt <= 16'h0000;
      abort_cnt <= 16'h0000;
    end else if (!run) begin
      sa_strobe <= 1'b0;
    end else begin
      sa_strobe <= ~sa_strobe;
      if (sa_strobe) sa_pos <= sa_pos + 3'h1;
      if (take) begin
        // Link looped back to the device receiver
        rx_sa_bit <= tx_sa_bit;
        last8 <= nxt_last8;
        ones <= tx_sa_bit ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
        if (nxt_last8 == 8'h7E) flag_cnt <= flag_cnt + 16'h0001;
        if (tx_sa_bit && ones == 3'h6) abort_cnt <= abort_cnt + 16'h0001;
      end
    end
  end
endmodule // sa_far_end

// *** tb/testbench.sv ***
// Self-checking bench for the Sa-bit link controller
`timescale 1ns/10ps
module testbench;
  import sa_hdlc_pkg::*;
  localparam logic [31:0] RX = 32'h0000_0080;
  localparam logic [31:0] TX = 32'h0000_0040;
  localparam logic [31:0] AB = 32'h0000_0020;
  localparam logic [31:0] EM = 32'h0000_0010;
  localparam logic [31:0] TH = 32'h0000_0004;
  localparam logic [31:0] RH = 32'h0000_0008;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic run = 1'b0;
  logic wr_busy = 1'b0;
  logic [4:0] sel = 5'h00;
  logic awready, wready, bvalid, arready, rvalid, sa_strobe, rx_sa_bit, tx_sa_bit;
  logic tx_irq, rx_irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_v;
  logic [2:0] sa_pos;
  logic [15:0] flag_cnt, abort_cnt;
  int bad_count = 0, total_checks = 0, cyc = 0, tx_n = 0, rx_n = 0;

  sa_hdlc_link dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sa_strobe(sa_strobe), .sa_pos(sa_pos), .rx_sa_bit(rx_sa_bit), .tx_sa_bit(tx_sa_bit),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  sa_far_end far (.aclk(aclk), .aresetn(aresetn), .run(run), .sel(sel), .tx_sa_bit(tx_sa_bit),
    .sa_strobe(sa_strobe), .sa_pos(sa_pos), .rx_sa_bit(rx_sa_bit), .flag_cnt(flag_cnt),
    .abort_cnt(abort_cnt));

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tx_irq === 1'b1) tx_n <= tx_n + 1;
    if (rx_irq === 1'b1) rx_n <= rx_n + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wr_busy = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    wr_busy = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd_v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Waits a bounded time for an interrupt count to reach target
  task automatic wait_irq(input bit tx_side, input int target);
    int k;
    for (k = 0; k < 4000 && (tx_side ? tx_n : rx_n) < target; k++) @(posedge aclk);
    chk({31'h0, (tx_side ? tx_n : rx_n) >= target}, 32'h1, "interrupt wait");
  endtask

  task automatic t_regs;
    rd(CTRL_ADDR);
    chk(rd_v, 32'h0000_0000, "control reset");
    rd(SASEL_ADDR);
    chk(rd_v, 32'h0000_0000, "select reset");
    wr(CTRL_ADDR, 32'h0000_00FF);
    rd(CTRL_ADDR);
    chk(rd_v, 32'h0000_00FC, "control bits");
    wr(SASEL_ADDR, 32'hFFFF_FFFF);
    rd(SASEL_ADDR);
    chk(rd_v, 32'h0000_001F, "select bits");
    wr(12'h0FC, 32'h0000_0001);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    rd(12'h0FC);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(CTRL_ADDR, 32'h0000_0000);
  endtask

  task automatic t_flags;
    logic [15:0] f0;
    sel <= 5'h05;
    wr(SASEL_ADDR, 32'h0000_0005);
    wr(CTRL_ADDR, TX);
    f0 = flag_cnt;
    run <= 1'b1;
    repeat (400) @(posedge aclk);
    chk({31'h0, (flag_cnt - f0) >= 16'h0004}, 32'h1, "idle flags");
    run <= 1'b0;
    wr(CTRL_ADDR, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    chk({31'h0, tx_sa_bit}, 32'h1, "disabled line");
  endtask

  task automatic t_loop;
    int t0, r0;
    t0 = tx_n;
    r0 = rx_n;
    sel <= 5'h1F;
    wr(SASEL_ADDR, 32'h0000_001F);
    wr(CTRL_ADDR, RX | TX);
    wr(TXD_ADDR, 32'h0000_00A5);
    wr(TXD_ADDR, 32'h0000_003C);
    wr(CTRL_ADDR, RX | TX | EM);
    run <= 1'b1;
    wait_irq(1'b1, t0 + 1);
    wait_irq(1'b0, r0 + 1);
    run <= 1'b0;
    rd(STAT_ADDR);
    chk({27'h0, rd_v[4:0]}, 32'h2, "received bytes");
    rd(RXD_ADDR);
    chk(rd_v, 32'h0000_00A5, "first byte");
    wr(CTRL_ADDR, TX);
    rd(STAT_ADDR);
    chk({27'h0, rd_v[4:0]}, 32'h0, "receive flushed");
  endtask

  task automatic t_fill;
    int t0, r0, k;
    t0 = tx_n;
    r0 = rx_n;
    wr(CTRL_ADDR, 32'h0000_0000);
    wr(CTRL_ADDR, RX | TX | TH | RH | EM);
    for (k = 0; k < 16; k++) wr(TXD_ADDR, k);
    rd(STAT_ADDR);
    chk({27'h0, rd_v[12:8]}, 32'h10, "transmit full");
    fork
      wr(TXD_ADDR, 32'h0000_0010);
    join_none
    repeat (30) @(posedge aclk);
    chk({31'h0, wr_busy}, 32'h1, "write held while full");
    run <= 1'b1;
    for (k = 0; k < 500 && wr_busy; k++) @(posedge aclk);
    wait_irq(1'b1, t0 + 1);
    wait_irq(1'b1, t0 + 2);
    wait_irq(1'b0, r0 + 3);
    chk(rx_n - r0, 32'h3, "receive half, overflow and end");
    run <= 1'b0;
  endtask

  task automatic t_abort;
    logic [15:0] a0, f0;
    int k, r0;
    wr(CTRL_ADDR, TX);
    r0 = rx_n;
    for (k = 0; k < 4; k++) wr(TXD_ADDR, 32'h0000_0055);
    a0 = abort_cnt;
    wr(CTRL_ADDR, TX | AB);
    run <= 1'b1;
    for (k = 0; k < 2000 && abort_cnt == a0; k++) @(posedge aclk);
    chk({31'h0, abort_cnt != a0}, 32'h1, "abort on line");
    f0 = flag_cnt;
    repeat (300) @(posedge aclk);
    chk({31'h0, (flag_cnt - f0) >= 16'h0004}, 32'h1, "flags after abort");
    rd(STAT_ADDR);
    chk({27'h0, rd_v[12:8]}, 32'h0, "transmit discarded");
    rd(CTRL_ADDR);
    chk(rd_v & AB, 32'h0, "abort cleared");
    chk(rx_n - r0, 32'h0, "receive silent");
    run <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_flags();
    t_loop();
    t_fill();
    t_abort();
    end_of_test();
  end
endmodule // testbench
